/* File: rtl/flight_computer_discrete_channels.sv */
`timescale 1ns/100ps
`include "discrete_channels_defs.svh"
// Summary of operation
// - controller, thruster, radar words: 15 bits, inverted
// - status bit7 radar converter fail, bit9 operate
// - status bits 10..15 guidance, cage, fail, temp
// - three-bit radar select code picks quantity
// - controller bits 1..6 pitch, yaw, roll
// - controller bits 13..15 hold, auto, detent
// - thruster fail bits 1..8 stop pair commands
// - thruster bit 9 gimbal actuators off
// - radar bit 2 rendezvous power, computer mode
// - radar bit 3 rendezvous low scale
// - radar bits 4,5 range tracker lock
// - radar bits 6,7 landing antenna position
// - radar bit 8 velocity tracker lock
// - radar bit 9 landing radar low scale
// - radar bit 10 uplink inhibit reads zero
// - radar bits 11..15 rate, loop, alarms
// - two downlink words, 16 bits with parity
// - keys give five-bit codes, proceed excluded
// - relay word: bits 12..15 group, 1..11 relays
// - display fields, rows and lights via relays
// - status word 15 bits, inverted
// - key press loads dedicated key-code channel
module flight_computer_discrete_channels
  import discrete_channels_pkg::*;
(
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // discrete inputs, condition active high
  input  wire logic [`DISC_W-1:0]          system_status_pins,
  input  wire logic [`DISC_W-1:0]          hand_controller_pins,
  input  wire logic [`DISC_W-1:0]          thruster_fail_pins,
  input  wire logic [`DISC_W-1:0]          radar_alarm_pins,
  // keyboard_display_unit keyboard
  input  wire logic [`KEY_W-1:0]           key_code_pins,
  input  wire logic                        key_strobe_pin,
  // outputs to spacecraft equipment
  output logic [2:0]                       radar_select,
  output logic [`THR_PAIRS-1:0]            thruster_pair_on,
  output logic [`DOWNLINK_W-1:0]           downlink_first,
  output logic [`DOWNLINK_W-1:0]           downlink_second,
  output logic                             downlink_first_load,
  output logic                             downlink_second_load,
  // keyboard_display_unit relay matrix
  output logic [`RELAY_GROUPS*`RELAY_DATA_W-1:0] relay_matrix
);

  localparam int NW = 4;

  // input synchronisers: two flops, then a stable-word stage
  logic [`DISC_W-1:0] sync1 [NW];
  logic [`DISC_W-1:0] sync2 [NW];
  logic [`DISC_W-1:0] prev  [NW];
  logic [`DISC_W-1:0] word  [NW];
  logic [`DISC_W-1:0] pins  [NW];

  always_comb begin
    pins[0] = system_status_pins;
    pins[1] = hand_controller_pins;
    pins[2] = thruster_fail_pins;
    pins[3] = radar_alarm_pins;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NW; i++) begin
        sync1[i] <= '0;
        sync2[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NW; i++) begin
        sync1[i] <= pins[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  // a word is only taken once it held still for a cycle, so bits
  // that crossed on different edges never show up mixed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NW; i++) begin
        prev[i] <= '0;
        word[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NW; i++) begin
        prev[i] <= sync2[i];
        if (prev[i] == sync2[i]) begin
          word[i] <= sync2[i];
        end
      end
    end
  end

  // inverted logic: an asserted condition reads as zero
  function automatic logic [`DISC_W-1:0] invert_word(
    input logic [`DISC_W-1:0] w
  );
    invert_word = ~w;
  endfunction : invert_word

  logic [`DISC_W-1:0] status_view;
  logic [`DISC_W-1:0] hand_view;
  logic [`DISC_W-1:0] thruster_view;
  logic [`DISC_W-1:0] radar_view;

  always_comb begin
    // bit layout passes straight through: index N-1 is bit N
    status_view   = invert_word(word[0]);
    hand_view     = invert_word(word[1]);
    thruster_view = invert_word(word[2]);
    radar_view    = invert_word(word[3]);
    radar_view[`RADAR_UPLINK_INHIBIT_BIT] = 1'b0;
  end

  // keyboard: code pins and strobe cross through two flops only, with no stable-word stage
  logic [`KEY_W-1:0] key_sync1;
  logic [`KEY_W-1:0] key_sync2;
  logic              strobe_sync1;
  logic              strobe_sync2;
  logic              strobe_last;
  logic [`KEY_W-1:0] key_code;
  logic              key_pending;
  logic              key_press;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_sync1    <= '0;
      key_sync2    <= '0;
      strobe_sync1 <= 1'b0;
      strobe_sync2 <= 1'b0;
      strobe_last  <= 1'b0;
    end else begin
      key_sync1    <= key_code_pins;
      key_sync2    <= key_sync1;
      strobe_sync1 <= key_strobe_pin;
      strobe_sync2 <= strobe_sync1;
      strobe_last  <= strobe_sync2;
    end
  end

  // code is taken in the cycle the strobe edge reaches strobe_sync2, so that it has
  // been through both stages while the strobe was still rising
  assign key_press = strobe_sync2 && !strobe_last;

  // ahb-lite address phase
  logic       take;
  logic       rd_take;
  logic       wr_pend;
  logic [7:0] wr_off;

  assign take    = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;

  logic key_read;
  assign key_read = rd_take && (haddr[7:0] == `OFF_KEY_CODE)
                    && (haddr[31:8] == 24'h000000);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_code <= '0;
    end else if (key_press) begin
      key_code <= key_sync2;
    end
  end

  // a press in the very cycle of the read stays pending
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_pending <= 1'b0;
    end else if (key_press) begin
      key_pending <= 1'b1;
    end else if (key_read) begin
      key_pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_off  <= 8'h00;
    end else if (hready) begin
      wr_pend <= take && hwrite && (haddr[31:8] == 24'h000000);
      wr_off  <= haddr[7:0];
    end
  end

  function automatic logic wr_hit(
    input logic       pend,
    input logic [7:0] off,
    input logic [7:0] want
  );
    wr_hit = pend && (off == want);
  endfunction : wr_hit

  // odd parity over the 15 data bits
  function automatic logic [`DOWNLINK_W-1:0] with_parity(
    input logic [31:0] d
  );
    logic [`DOWNLINK_W-1:0] w;
    w = {1'b0, d[`DISC_W-1:0]};
    w[`DOWNLINK_PARITY_BIT] = ~(^d[`DISC_W-1:0]);
    with_parity = w;
  endfunction : with_parity

  // downlink words
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      downlink_first      <= `RST_DOWNLINK;
      downlink_first_load <= 1'b0;
    end else begin
      downlink_first_load <= 1'b0;
      if (wr_hit(wr_pend, wr_off, `OFF_DOWNLINK_FIRST)) begin
        downlink_first      <= with_parity(hwdata);
        downlink_first_load <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      downlink_second      <= `RST_DOWNLINK;
      downlink_second_load <= 1'b0;
    end else begin
      downlink_second_load <= 1'b0;
      if (wr_hit(wr_pend, wr_off, `OFF_DOWNLINK_SEC)) begin
        downlink_second      <= with_parity(hwdata);
        downlink_second_load <= 1'b1;
      end
    end
  end

  // radar select
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      radar_select <= `RST_RADAR_SEL;
    end else if (wr_hit(wr_pend, wr_off, `OFF_RADAR_SELECT)) begin
      radar_select <= hwdata[2:0];
    end
  end

  // thruster pair commands, gated by the live failure flags
  logic [`THR_PAIRS-1:0] thruster_cmd;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      thruster_cmd <= `RST_THR_CMD;
    end else if (wr_hit(wr_pend, wr_off, `OFF_THRUSTER_CMD)) begin
      thruster_cmd <= hwdata[`THR_PAIRS-1:0];
    end
  end

  // gated from the second sync stage, not the stable word, so a
  // shut-off pair is dropped without waiting for software
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      thruster_pair_on <= '0;
    end else begin
      thruster_pair_on <= thruster_cmd
                          & ~sync2[2][`THR_PAIRS-1:0];
    end
  end

  // relay matrix: each group keeps its 11 relays until rewritten
  logic [`RELAY_DATA_W-1:0] relay_grp [`RELAY_GROUPS];
  logic [`RELAY_GRP_W-1:0]  grp_sel;

  assign grp_sel = hwdata[`RELAY_GRP_LSB +: `RELAY_GRP_W];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int g = 0; g < `RELAY_GROUPS; g++) begin
        relay_grp[g] <= '0;
      end
    end else if (wr_hit(wr_pend, wr_off, `OFF_RELAY_WORD)) begin
      // the word itself is not held; the group latches are the state
      // group code 0 selects nothing, so a blank word is harmless
      if (grp_sel != '0) begin
        relay_grp[grp_sel] <= hwdata[`RELAY_DATA_W-1:0];
      end
    end
  end

  always_comb begin
    for (int g = 0; g < `RELAY_GROUPS; g++) begin
      relay_matrix[g*`RELAY_DATA_W +: `RELAY_DATA_W] = relay_grp[g];
    end
  end

  // read mux, registered at the end of the address phase
  logic [31:0] next_hrdata;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (haddr[31:8] == 24'h000000) begin
      case (haddr[7:0])
        `OFF_SYS_STATUS:    next_hrdata[`DISC_W-1:0] = status_view;
        `OFF_HAND_CTRL:     next_hrdata[`DISC_W-1:0] = hand_view;
        `OFF_THRUSTER_FAIL: next_hrdata[`DISC_W-1:0] = thruster_view;
        `OFF_RADAR_ALARM:   next_hrdata[`DISC_W-1:0] = radar_view;
        `OFF_KEY_CODE: begin
          next_hrdata[`KEY_W-1:0]        = key_code;
          next_hrdata[`KEY_PENDING_BIT]  = key_pending;
        end
        `OFF_RADAR_SELECT:  next_hrdata[2:0] = radar_select;
        `OFF_THRUSTER_CMD:  next_hrdata[`THR_PAIRS-1:0] = thruster_cmd;
        // write-only words and unmapped space read zero
        default:            next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= next_hrdata;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : flight_computer_discrete_channels

/* File: rtl/discrete_channels_defs.svh */
`ifndef DISCRETE_CHANNELS_DEFS_SVH
`define DISCRETE_CHANNELS_DEFS_SVH

// register byte offsets
`define OFF_SYS_STATUS     8'h00
`define OFF_HAND_CTRL      8'h04
`define OFF_THRUSTER_FAIL  8'h08
`define OFF_RADAR_ALARM    8'h0C
`define OFF_DOWNLINK_FIRST 8'h10
`define OFF_DOWNLINK_SEC   8'h14
`define OFF_RELAY_WORD     8'h18
`define OFF_KEY_CODE       8'h1C
`define OFF_RADAR_SELECT   8'h20
`define OFF_THRUSTER_CMD   8'h24

// widths
`define DISC_W     15
`define DOWNLINK_W 16
`define KEY_W      5
`define RELAY_DATA_W 11
`define RELAY_GRP_W  4
`define RELAY_GROUPS 16
`define THR_PAIRS  8

// field positions (bit N of a word sits at index N-1)
`define RADAR_UPLINK_INHIBIT_BIT 9
`define DOWNLINK_PARITY_BIT      15
`define KEY_PENDING_BIT          5
`define RELAY_GRP_LSB            11

// reset values
`define RST_DOWNLINK   16'h0000
`define RST_RELAY      15'h0000
`define RST_RADAR_SEL  3'h0
`define RST_THR_CMD    8'h00

`endif

/* File: rtl/discrete_channels_pkg.sv */
package discrete_channels_pkg;

  typedef enum logic [2:0] {
    RSEL_RENDEZVOUS_RANGE_RATE = 3'b000,
    RSEL_RENDEZVOUS_RANGE      = 3'b001,
    RSEL_LANDING_VEL_X         = 3'b100,
    RSEL_LANDING_VEL_Y         = 3'b101,
    RSEL_LANDING_VEL_Z         = 3'b110,
    RSEL_LANDING_RANGE         = 3'b111
  } radar_select_t;

  typedef enum logic [1:0] {
    HTRANS_IDLE   = 2'b00,
    HTRANS_BUSY   = 2'b01,
    HTRANS_NONSEQ = 2'b10,
    HTRANS_SEQ    = 2'b11
  } htrans_t;

endpackage : discrete_channels_pkg

/* File: verification/discrete_channels_props.sv */
`timescale 1ns/100ps
`include "discrete_channels_defs.svh"
module discrete_channels_props (
  // clock, reset and bus
  input wire logic                 core_clk,
  input wire logic                 rstn,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  // discretes
  input wire logic [`DISC_W-1:0]   thruster_fail_pins,
  input wire logic [2:0]           radar_select,
  input wire logic [7:0]           thruster_pair_on,
  input wire logic [15:0]          downlink_first,
  input wire logic                 downlink_first_load,
  input wire logic [175:0]         relay_matrix
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] up;
  logic       tk;
  // input words need a few cycles after reset to settle
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) up <= 4'h0;
    else if (up != 4'hF) up <= up + 4'h1;
  assign tk = hsel && hready && htrans[1];

  a_uplink_reads_zero:
    assert property (tk && !hwrite && haddr[7:0] == 8'h0C |=> !hrdata[9])
    else $error("uplink inhibit bit read high");
  a_inputs_read_inverted:
    assert property ((up == 4'hF && $stable(thruster_fail_pins)) [*6]
      ##0 (tk && !hwrite && haddr[7:0] == 8'h08)
      |=> hrdata == {17'h0, ~$past(thruster_fail_pins)})
    else $error("input word not inverted");
  a_pair_gated_off:
    assert property ($stable(thruster_fail_pins) [*3]
      |-> (thruster_pair_on & thruster_fail_pins[7:0]) == 8'h0)
    else $error("failed pair still commanded");
  a_downlink_parity_odd:
    assert property (downlink_first_load |-> ^downlink_first)
    else $error("downlink parity even");
  a_downlink_load_data:
    assert property (tk && hwrite && haddr[7:0] == 8'h10 ##1 1'b1
      |=> downlink_first_load
          && downlink_first[14:0] == $past(hwdata[14:0]))
    else $error("downlink word not loaded");
  a_relay_group_write:
    assert property (tk && hwrite && haddr[7:0] == 8'h18
      ##1 hwdata[14:11] != 4'h0
      |=> 11'(relay_matrix >> ($past(hwdata[14:11]) * 11))
          == $past(hwdata[10:0]))
    else $error("relay group not set");
  a_group_zero_idle:
    assert property (relay_matrix[10:0] == 11'h0)
    else $error("relay group zero driven");
  a_radar_code_write:
    assert property (tk && hwrite && haddr[7:0] == 8'h20 ##1 1'b1
      |=> radar_select == $past(hwdata[2:0]))
    else $error("radar select not written");
  a_upper_read_zero:
    assert property (tk && !hwrite |=> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
endmodule : discrete_channels_props

bind flight_computer_discrete_channels discrete_channels_props u_props (
  .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .thruster_fail_pins, .radar_select, .thruster_pair_on,
  .downlink_first, .downlink_first_load, .relay_matrix
);

/* File: verification/spacecraft_equipment.sv */
`timescale 1ns/100ps
`include "discrete_channels_defs.svh"
module spacecraft_equipment (
  // pacing clock
  input wire logic                core_clk,
  // condition discretes
  output logic [`DISC_W-1:0]      system_status_pins,
  output logic [`DISC_W-1:0]      hand_controller_pins,
  output logic [`DISC_W-1:0]      thruster_fail_pins,
  output logic [`DISC_W-1:0]      radar_alarm_pins,
  // keyboard
  output logic [`KEY_W-1:0]       key_code_pins,
  output logic                    key_strobe_pin
);
  initial begin
    system_status_pins = '0;
    hand_controller_pins = '0;
    thruster_fail_pins = '0;
    radar_alarm_pins = '0;
    key_code_pins = '0;
    key_strobe_pin = 1'b0;
  end
  task automatic set_word(input int w, input logic [`DISC_W-1:0] v);
    @(posedge core_clk);
    case (w)
      0: system_status_pins <= v;
      1: hand_controller_pins <= v;
      2: thruster_fail_pins <= v;
      default: radar_alarm_pins <= v;
    endcase
  endtask : set_word
  // proceed key is hardwired elsewhere, so it never comes here
  task automatic press_key(input logic [`KEY_W-1:0] c);
    @(posedge core_clk);
    key_code_pins <= c;
    repeat (4) @(posedge core_clk);
    key_strobe_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    // code no longer held, so show garbage rather than the old value
    key_code_pins <= ~c;
    key_strobe_pin <= 1'b0;
  endtask : press_key
endmodule : spacecraft_equipment

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
`include "discrete_channels_defs.svh"
module tb_top import discrete_channels_pkg::*; ;
  logic                     core_clk, rstn, hsel, hwrite, hready;
  logic                     hreadyout, hresp, key_strobe_pin;
  logic                     downlink_first_load, downlink_second_load;
  logic [31:0]              haddr, hwdata, hrdata, d;
  logic [1:0]               htrans;
  logic [2:0]               hsize, radar_select;
  logic [`DISC_W-1:0]       system_status_pins, hand_controller_pins;
  logic [`DISC_W-1:0]       thruster_fail_pins, radar_alarm_pins;
  logic [4:0]               key_code_pins;
  logic [7:0]               thruster_pair_on;
  logic [15:0]              downlink_first, downlink_second;
  logic [175:0]             relay_matrix;
  logic [2:0]               codes [6] = '{3'h0, 3'h1, 3'h4,
                                          3'h5, 3'h6, 3'h7};
  int                       fail_count, n_tests;

  assign hready = hreadyout;
  flight_computer_discrete_channels dut (.*);
  spacecraft_equipment eq (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    d = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(d, e);
  endtask : rchk
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #40000;
    fail_count++;
    finish_test();
  end
  initial begin
    {rstn, hsel, hwrite, haddr, hwdata} = '0;
    htrans = HTRANS_IDLE;
    hsize = 3'h2;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    rchk(`OFF_SYS_STATUS, 32'h7FFF);
    rchk(`OFF_HAND_CTRL, 32'h7FFF);
    rchk(`OFF_RADAR_ALARM, 32'h7DFF);
    bus(1'b1, `OFF_THRUSTER_CMD, 32'hFF);
    repeat (2) @(posedge core_clk);
    check({24'h0, thruster_pair_on}, 32'hFF);
    rchk(`OFF_THRUSTER_CMD, 32'h00FF);
    eq.set_word(0, 15'h7F40);
    eq.set_word(1, 15'h703F);
    eq.set_word(2, 15'h01A5);
    eq.set_word(3, 15'h7DFE);
    repeat (8) @(posedge core_clk);
    check({24'h0, thruster_pair_on}, 32'h5A);
    rchk(`OFF_SYS_STATUS, 32'h00BF);
    rchk(`OFF_HAND_CTRL, 32'h0FC0);
    rchk(`OFF_THRUSTER_FAIL, 32'h7E5A);
    rchk(`OFF_RADAR_ALARM, 32'h0001);
    eq.set_word(1, 15'h0000);
    rchk(`OFF_HAND_CTRL, 32'h0FC0);
    repeat (4) @(posedge core_clk);
    rchk(`OFF_HAND_CTRL, 32'h7FFF);
    foreach (codes[i]) begin
      bus(1'b1, `OFF_RADAR_SELECT, {29'h0, codes[i]});
      @(posedge core_clk);
      check({29'h0, radar_select}, {29'h0, codes[i]});
    end
    rchk(`OFF_RADAR_SELECT, 32'h0007);
    bus(1'b1, `OFF_DOWNLINK_FIRST, 32'h0001);
    bus(1'b1, `OFF_DOWNLINK_SEC, 32'h0003);
    @(posedge core_clk);
    check({30'h0, downlink_first_load, downlink_second_load}, 32'h1);
    check({16'h0, downlink_first}, 32'h0001);
    check({16'h0, downlink_second}, 32'h8003);
    rchk(`OFF_DOWNLINK_FIRST, 32'h0);
    bus(1'b1, `OFF_RELAY_WORD, 32'h1DA5);
    bus(1'b1, `OFF_RELAY_WORD, 32'h7FFF);
    bus(1'b1, `OFF_RELAY_WORD, 32'h0123);
    @(posedge core_clk);
    check({21'h0, relay_matrix[33+:11]}, 32'h5A5);
    check({21'h0, relay_matrix[165+:11]}, 32'h7FF);
    check({21'h0, relay_matrix[10:0]}, 32'h0);
    eq.press_key(5'h15);
    repeat (6) @(posedge core_clk);
    rchk(`OFF_KEY_CODE, 32'h35);
    bus(1'b0, `OFF_KEY_CODE, 32'h0);
    check(d & 32'h20, 32'h0);
    check({31'h0, hresp}, 32'h0);
    rchk(8'hFC, 32'h0);
    finish_test();
  end
endmodule : tb_top
